// ==== verif/dbs_power_stage.sv ====
// Purpose: Power stage and motor stand-in for the drive controller
// Assumes: Supply steady, motor current follows output state
// Notes: Fixed current level keeps the current-based lift predictable
`timescale 1ns/1ps
`default_nettype none
module dbs_power_stage #(
   parameter logic [9:0] VIN = 10'h17c,
   parameter logic [11:0] TORQUE = 12'h100
) (
   input wire logic output_on,
   input wire logic dc_inject,
   output logic [9:0] vin_meas,
   output logic [11:0] torque_cur
);
   assign vin_meas = VIN;
   // No torque current unless switching or injecting
   assign torque_cur = (output_on | dc_inject) ? TORQUE : 12'h000;
endmodule
`default_nettype wire

// ==== verif/drive_boost_start_stop_seq_tb.sv ====
// Purpose: Self-checking bench for the drive controller
// Assumes: Tick of 10 cycles, motor stand-in at 380 V
// Notes: Lift table runs at zero reference, so only the lift term shows
`timescale 1ns/1ps
`default_nettype none
module drive_boost_start_stop_seq_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err_q, output_on, dc_inject;
   logic [9:0] vin_meas, volt_cmd;
   logic [11:0] torque_cur;
   logic [15:0] freq_cmd;
   logic [7:0] dc_level;
   logic [11:0] t_ctl [8] = '{12'h001, 12'h003, 12'h001, 12'h001, 12'h005, 12'h011, 12'h021, 12'h031};
   logic [9:0] t_rat [8] = '{10'h190, 10'h190, 10'h0c8, 10'h000, 10'h190, 10'h190, 10'h190, 10'h190};
   logic [9:0] t_exp [8] = '{10'h039, 10'h007, 10'h01e, 10'h039, 10'h000, 10'h020, 10'h040, 10'h000};
   int errors = 0, check_count = 0, n;
   always #5 pclk = ~pclk;
   dbs_drive_ctrl #(.TICK_CYCLES(10)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .vin_meas, .torque_cur, .freq_cmd, .volt_cmd,
      .output_on, .dc_inject, .dc_level);
   dbs_power_stage ps_u (.output_on, .dc_inject, .vin_meas, .torque_cur);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: only the watchdog may end a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts edges until the chosen condition reaches lvl
   task automatic wait_for(input int sel, input logic lvl);
      n = 0;
      while (n < 2000 && ((sel == 0) ? output_on : (sel == 1) ? dc_inject :
             (freq_cmd == 16'h03e8)) !== lvl) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 2000) chk("wait level", {31'h0, lvl}, {31'h0, ~lvl});
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      chk("timeout", 32'h0, 32'h1);
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, dbs_pkg::REG_LIFT, 32'h0); chk("lift reset", 32'h0000_1414, q);
      apb(1'b0, dbs_pkg::REG_START, 32'h0); chk("start reset", 32'h0032_0000, q);
      apb(1'b0, dbs_pkg::REG_STOP_T, 32'h0); chk("stop time reset", 32'h0064_000a, q);
      apb(1'b0, dbs_pkg::REG_STOP_L, 32'h0); chk("stop level reset", 32'h01f4_0032, q);
      apb(1'b0, 4'hb, 32'h0);
      chk("unmapped error", {31'h0, 1'b1}, {31'h0, err_q});
      apb(1'b1, dbs_pkg::REG_STATUS, 32'h5);
      chk("read-only error", {31'h0, 1'b1}, {31'h0, err_q});
      $display("test registers done");
      apb(1'b1, dbs_pkg::REG_LIFT, 32'h0040_1496);
      apb(1'b1, dbs_pkg::REG_MODEL, 32'h2000_0100);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, dbs_pkg::REG_VOLT, {22'h000190, t_rat[i]});
         apb(1'b1, dbs_pkg::REG_CTRL, {20'h0, t_ctl[i]});
         repeat (6) @(posedge pclk);
         chk("lift volt", {22'h0, t_exp[i]}, {22'h0, volt_cmd});
         chk("running", 32'h1, {31'h0, output_on});
      end
      $display("test lift done");
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h0);
      wait_for(0, 1'b0);
      apb(1'b1, dbs_pkg::REG_START, 32'h0050_0003);
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h101);
      @(posedge pclk);
      #1;
      chk("launch inject", 32'h1, {31'h0, dc_inject & ~output_on});
      chk("launch level", 32'h50, {24'h0, dc_level});
      wait_for(0, 1'b1);
      chk("launch span", 32'h1, {31'h0, n >= 15 && n <= 32});
      chk("launch end", 32'h0, {31'h0, dc_inject});
      $display("test launch done");
      apb(1'b1, dbs_pkg::REG_STOP_T, 32'h0004_0002);
      apb(1'b1, dbs_pkg::REG_STOP_L, 32'h01f4_0046);
      apb(1'b1, dbs_pkg::REG_DWELL, 32'h0064_012c);
      apb(1'b1, dbs_pkg::REG_FREQ, 32'h1770_03e8);
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h201);
      wait_for(2, 1'b1);
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h200);
      wait_for(0, 1'b0);
      chk("threshold", 32'h1, {31'h0, freq_cmd <= 16'h01f4 && !dc_inject});
      wait_for(1, 1'b1);
      chk("off span", 32'h1, {31'h0, n >= 8 && n <= 24});
      chk("halt level", 32'h46, {24'h0, dc_level});
      wait_for(1, 1'b0);
      chk("halt span", 32'h1, {31'h0, n >= 28 && n <= 44});
      chk("halt end", 32'h0, {23'h0, output_on, dc_level});
      apb(1'b0, dbs_pkg::REG_STATUS, 32'h0); chk("idle", 32'h0, {29'h0, q[2:0]});
      $display("test halt done");
      // Dwell at 6.00 Hz for 20 ticks, now above the threshold
      apb(1'b1, dbs_pkg::REG_DWELL, 32'h0014_0258);
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h001);
      repeat (12) @(posedge pclk);
      chk("ramp start", 32'h1, {31'h0, freq_cmd != 16'h0 && !dc_inject});
      wait_for(2, 1'b1);
      apb(1'b1, dbs_pkg::REG_CTRL, 32'h000);
      repeat (800) @(posedge pclk);
      apb(1'b0, dbs_pkg::REG_STATUS, 32'h0);
      chk("dwell", {16'h0256, 16'h0004}, {q[31:16], 13'h0, q[2:0]});
      wait_for(0, 1'b0);
      chk("ramp stop", 32'h0, {15'h0, dc_inject, freq_cmd});
      $display("test ramp done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== verilog/dbs_drive_ctrl.sv ====
// Purpose: Voltage lift, output voltage limit and start-stop sequencing
// Assumes: Plain APB master; vin_meas and torque_cur synchronous to pclk
// Notes: Frequency in 0.01 Hz, voltage in V, times in 10 ms ticks
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) Manual lift mode 0 raises voltage at start and low speed by set percent.
// (R2) Forward lift percent applies only when running forward; 0.0-15.0, default 2.0.
// (R3) Reverse lift percent applies when running reverse; same range and default.
// (R4) Controller must tune motor before selecting model-based lift mode 1; the code has no tuning step and accepts mode 1 at any time.
// (R5) Mode 2 adds voltage derived from measured torque current.
// (R6) Rated voltage, 170-480 or 0, is voltage at base frequency and above.
// (R7) Rated voltage above input voltage is limited to input voltage.
// (R8) Rated zero scales from stopped input voltage; lower live input wins above base.
// (R9) Start mode 0 begins ramping toward reference at once on run.
// (R10) Start mode 1 injects DC for launch time, then accelerates.
// (R11) Launch injection amount is 0-200 percent of rated current, default 50.
// (R12) Ramp stop brings frequency to zero then stops driving.
// (R13) Injection stop ramps to threshold, default 5.00 Hz, then injects DC.
// (R14) Output is off for the pre-injection time between threshold and injection.
// (R15) Halt injection lasts the set duration, 0-60 s, default 1.00 s.
// (R16) Halt injection amount is 0-200 percent of rated current.
// (R17) Dwell below threshold is skipped; braking starts at threshold instead.
// (R18) User volt/frequency pattern disables forward and reverse lift percent.
// (R19) Halt injection end turns output off and returns to stopped state.
// (R20) Timed states use a 10 ms timer loaded on state entry.
module dbs_drive_ctrl #(
   parameter int TICK_CYCLES = dbs_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] vin_meas,
   input wire logic [11:0] torque_cur,
   output logic [15:0] freq_cmd,
   output logic [9:0] volt_cmd,
   output logic output_on,
   output logic dc_inject,
   output logic [7:0] dc_level
);
   initial begin
      if (TICK_CYCLES < 1) $error("dbs_drive_ctrl: TICK_CYCLES must be positive");
   end
   ////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait-free access phase
   logic [31:0] cfg_r [0:dbs_pkg::NREG_CFG-1];
   logic [31:0] rd_words [0:dbs_pkg::NREG-1];
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   wire [3:0] idx = paddr[dbs_pkg::ADDR_LSB +: dbs_pkg::IDX_W];
   wire setup = psel & ~penable;
   wire access = psel & penable & pready_r;
   wire mapped = (idx < 4'(dbs_pkg::NREG)) && (paddr[1:0] == 2'h0);
   wire ro_hit = idx >= 4'(dbs_pkg::NREG_CFG);
   wire bad = ~mapped | (pwrite & ro_hit);
   wire [31:0] rd_sel = mapped ? rd_words[idx] : 32'h0000_0000;
   genvar gi;
   generate
      for (gi = 0; gi < dbs_pkg::NREG_CFG; gi++) begin : g_cfg
         wire wr_en = access & pwrite & ~bad & (idx == 4'(gi));
         assign rd_words[gi] = cfg_r[gi];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_r[gi] <= dbs_pkg::CFG_RST[gi];
            end else if (wr_en) begin
               cfg_r[gi] <= pwdata;
            end
         end
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         if (setup) begin
            pslverr_r <= bad;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_sel;
         end
      end
   end
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   ////////////////////////////////////////////////////////////////////////////
   // Field extraction and clamping
   wire [31:0] c_ctrl = cfg_r[dbs_pkg::REG_CTRL];
   wire [31:0] c_lift = cfg_r[dbs_pkg::REG_LIFT];
   wire [31:0] c_model = cfg_r[dbs_pkg::REG_MODEL];
   wire [31:0] c_volt = cfg_r[dbs_pkg::REG_VOLT];
   wire [31:0] c_freq = cfg_r[dbs_pkg::REG_FREQ];
   wire [31:0] c_start = cfg_r[dbs_pkg::REG_START];
   wire [31:0] c_stopt = cfg_r[dbs_pkg::REG_STOP_T];
   wire [31:0] c_stopl = cfg_r[dbs_pkg::REG_STOP_L];
   wire [31:0] c_dwell = cfg_r[dbs_pkg::REG_DWELL];
   wire run_cmd = c_ctrl[dbs_pkg::CTRL_RUN];
   wire dir_rev = c_ctrl[dbs_pkg::CTRL_REV];
   wire vf_user = c_ctrl[dbs_pkg::CTRL_VF_USER];
   wire [1:0] lift_mode = c_ctrl[dbs_pkg::CTRL_BOOST +: 2];
   wire start_mode = c_ctrl[dbs_pkg::CTRL_START];
   wire stop_mode = c_ctrl[dbs_pkg::CTRL_STOP];
   wire [7:0] fwd_raw = c_lift[dbs_pkg::LO +: 8];
   wire [7:0] rev_raw = c_lift[dbs_pkg::MID +: 8];
   wire [7:0] forward_lift_param = (fwd_raw > dbs_pkg::LIFT_MAX) ? dbs_pkg::LIFT_MAX : fwd_raw;
   wire [7:0] reverse_lift_param = (rev_raw > dbs_pkg::LIFT_MAX) ? dbs_pkg::LIFT_MAX : rev_raw;
   wire [15:0] cur_gain = c_lift[dbs_pkg::HI +: 16];
   wire [9:0] rated_raw = c_volt[dbs_pkg::LO +: 10];
   wire [9:0] rated = (rated_raw == 10'h000) ? 10'h000 :
                      (rated_raw < dbs_pkg::RATED_MIN) ? dbs_pkg::RATED_MIN :
                      (rated_raw > dbs_pkg::RATED_MAX) ? dbs_pkg::RATED_MAX : rated_raw;
   wire [15:0] ramp_step = c_volt[dbs_pkg::HI +: 16];
   wire [15:0] freq_ref = c_freq[dbs_pkg::LO +: 16];
   wire [15:0] base_raw = c_freq[dbs_pkg::HI +: 16];
   wire [15:0] base_f = (base_raw == 16'h0000) ? 16'h0001 : base_raw;
   function automatic logic [12:0] tclamp(input logic [12:0] t);
      tclamp = (t > dbs_pkg::TIME_MAX) ? dbs_pkg::TIME_MAX : t;
   endfunction
   function automatic logic [7:0] iclamp(input logic [7:0] a);
      iclamp = (a > dbs_pkg::INJ_MAX) ? dbs_pkg::INJ_MAX : a;
   endfunction
   wire [12:0] launch_injection_duration = tclamp(c_start[dbs_pkg::LO +: 13]);
   wire [7:0] launch_injection_amount = iclamp(c_start[dbs_pkg::HI +: 8]);
   wire [12:0] pre_injection_off_time = tclamp(c_stopt[dbs_pkg::LO +: 13]);
   wire [12:0] halt_injection_duration = tclamp(c_stopt[dbs_pkg::HI +: 13]);
   wire [7:0] halt_injection_amount = iclamp(c_stopl[dbs_pkg::LO +: 8]); // R16
   wire [15:0] halt_injection_threshold = c_stopl[dbs_pkg::HI +: 16];
   wire [15:0] dwell_freq = c_dwell[dbs_pkg::LO +: 16];
   wire [12:0] dwell_time = tclamp(c_dwell[dbs_pkg::HI +: 13]);
   ////////////////////////////////////////////////////////////////////////////
   // Output voltage: base voltage, volt/frequency ratio and lift
   dbs_pkg::dbs_state_e state_r, state_nxt;
   logic [15:0] freq_r, freq_nxt;
   logic [9:0] vin_hold_r;
   wire above_base = freq_r >= base_f;
   // Stopped sample tracks supply sag only while no voltage is applied
   wire [9:0] vb_auto = (above_base && vin_meas < vin_hold_r) ? vin_meas : vin_hold_r; // R8
   wire [9:0] vb_set = (rated > vin_meas) ? vin_meas : rated; // R7
   wire [9:0] vbase = (rated == 10'h000) ? vb_auto : vb_set; // R6
   wire [25:0] ratio_q = {freq_r, 10'h000} / {10'h000, base_f};
   wire [10:0] ratio = above_base ? dbs_pkg::RATIO_ONE : ratio_q[10:0];
   wire [20:0] vf_prod = vbase * ratio;
   wire [9:0] vf_v = vf_prod[dbs_pkg::RATIO_BITS +: 10];
   wire [7:0] pct_sel = dir_rev ? reverse_lift_param : forward_lift_param; // R2 R3
   wire [17:0] man_prod = vbase * pct_sel;
   wire [17:0] man_v = man_prod / {8'h00, dbs_pkg::PCT_SCALE}; // R1
   wire [31:0] mdl_prod = c_model[dbs_pkg::LO +: 16] * c_model[dbs_pkg::HI +: 16]; // R4
   wire [27:0] cur_prod = torque_cur * cur_gain; // R5
   logic [19:0] lift_raw;
   always_comb begin
      case (lift_mode)
         dbs_pkg::LIFT_MANUAL: lift_raw = vf_user ? 20'h00000 : {2'h0, man_v}; // R18
         dbs_pkg::MODEL_BASED_LIFT: lift_raw = {4'h0, mdl_prod[dbs_pkg::MODEL_SHIFT +: 16]};
         dbs_pkg::CURRENT_BASED_LIFT: lift_raw = cur_prod[dbs_pkg::CUR_SHIFT +: 20]; // R5
         default: lift_raw = 20'h00000;
      endcase
   end
   // Lift fades linearly to nothing at base frequency
   wire [10:0] fade = dbs_pkg::RATIO_ONE - ratio;
   wire [30:0] lift_prod = lift_raw * fade;
   wire [19:0] lift_v = lift_prod[dbs_pkg::RATIO_BITS +: 20]; // R1
   wire [20:0] vsum = {11'h000, vf_v} + {1'b0, lift_v};
   wire [9:0] volt_nxt = (vsum > {11'h000, vbase}) ? vbase : vsum[9:0]; // R6 R7
   ////////////////////////////////////////////////////////////////////////////
   // Start-stop sequencer
   logic tick, expired, t_load, dwell_done_r, dwell_done_nxt;
   logic [12:0] t_val;
   dbs_seq_timer #(.TICK_CYCLES(TICK_CYCLES), .TW(dbs_pkg::TIME_W)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(t_load),
      .load_val(t_val),
      .tick(tick),
      .expired(expired)
   );
   wire at_thresh = freq_r <= halt_injection_threshold;
   wire dwell_ok = (dwell_freq != 16'h0000) && (dwell_freq >= halt_injection_threshold); // R17
   wire [16:0] f_up = {1'b0, freq_r} + {1'b0, ramp_step};
   wire [15:0] f_acc = (f_up > {1'b0, freq_ref}) ? freq_ref : f_up[15:0];
   wire [15:0] f_dec = (freq_r > ramp_step) ? freq_r - ramp_step : 16'h0000;
   wire [15:0] f_dec_ref = (f_dec < freq_ref) ? freq_ref : f_dec;
   always_comb begin
      state_nxt = state_r;
      freq_nxt = freq_r;
      dwell_done_nxt = dwell_done_r;
      t_load = 1'b0;
      t_val = 13'h0000;
      case (state_r)
         dbs_pkg::ST_IDLE: begin
            freq_nxt = 16'h0000;
            dwell_done_nxt = 1'b0;
            if (run_cmd && start_mode == dbs_pkg::INJECTION_THEN_LAUNCH) begin
               state_nxt = dbs_pkg::ST_LAUNCH_INJ; // R10
               t_load = 1'b1; // R20
               t_val = launch_injection_duration;
            end else if (run_cmd) begin
               state_nxt = dbs_pkg::ST_RUN; // R9
            end
         end
         dbs_pkg::ST_LAUNCH_INJ: begin
            if (!run_cmd) state_nxt = dbs_pkg::ST_IDLE;
            else if (expired) state_nxt = dbs_pkg::ST_RUN; // R10
         end
         dbs_pkg::ST_RUN: begin
            dwell_done_nxt = 1'b0;
            if (!run_cmd) state_nxt = dbs_pkg::ST_DECEL;
            else if (tick && freq_r < freq_ref) freq_nxt = f_acc;
            else if (tick && freq_r > freq_ref) freq_nxt = f_dec_ref;
         end
         dbs_pkg::ST_DECEL: begin
            if (run_cmd) begin
               state_nxt = dbs_pkg::ST_RUN;
            end else if (stop_mode == dbs_pkg::HALT_INJECT && at_thresh) begin
               state_nxt = dbs_pkg::ST_BLOCK; // R13 R17
               t_load = 1'b1; // R20
               t_val = pre_injection_off_time;
            end else if (freq_r == 16'h0000) begin
               state_nxt = dbs_pkg::ST_IDLE; // R12
            end else if (dwell_ok && !dwell_done_r && freq_r <= dwell_freq) begin
               state_nxt = dbs_pkg::ST_DWELL;
               t_load = 1'b1; // R20
               t_val = dwell_time;
            end else if (tick) begin
               freq_nxt = f_dec; // R12
            end
         end
         dbs_pkg::ST_DWELL: begin
            if (expired) begin
               state_nxt = dbs_pkg::ST_DECEL;
               dwell_done_nxt = 1'b1;
            end
         end
         dbs_pkg::ST_BLOCK: begin
            freq_nxt = 16'h0000;
            if (expired) begin
               state_nxt = dbs_pkg::ST_HALT_INJ; // R14
               t_load = 1'b1; // R20
               t_val = halt_injection_duration; // R15
            end
         end
         dbs_pkg::ST_HALT_INJ: begin
            if (expired) state_nxt = dbs_pkg::ST_IDLE; // R19
         end
         default: state_nxt = dbs_pkg::ST_IDLE;
      endcase
   end
   wire drive_nxt = (state_nxt == dbs_pkg::ST_RUN) || (state_nxt == dbs_pkg::ST_DECEL) ||
                    (state_nxt == dbs_pkg::ST_DWELL);
   wire launch_nxt = state_nxt == dbs_pkg::ST_LAUNCH_INJ;
   wire halt_nxt = state_nxt == dbs_pkg::ST_HALT_INJ;
   logic [9:0] volt_r;
   logic on_r, inj_r;
   logic [7:0] lvl_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= dbs_pkg::ST_IDLE;
         freq_r <= 16'h0000;
         dwell_done_r <= 1'b0;
         vin_hold_r <= 10'h000;
         volt_r <= 10'h000;
         on_r <= 1'b0;
         inj_r <= 1'b0;
         lvl_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         freq_r <= freq_nxt;
         dwell_done_r <= dwell_done_nxt;
         if (state_r == dbs_pkg::ST_IDLE) vin_hold_r <= vin_meas; // R8
         volt_r <= drive_nxt ? volt_nxt : 10'h000;
         on_r <= drive_nxt; // R14 R19
         inj_r <= launch_nxt | halt_nxt;
         lvl_r <= launch_nxt ? launch_injection_amount : // R11
                  halt_nxt ? halt_injection_amount : 8'h00; // R16
      end
   end
   assign freq_cmd = freq_r;
   assign volt_cmd = volt_r;
   assign output_on = on_r;
   assign dc_inject = inj_r;
   assign dc_level = lvl_r;
   assign rd_words[dbs_pkg::REG_STATUS] = {freq_r, 13'h0000, 3'(state_r)};
   assign rd_words[dbs_pkg::REG_VOUT] = {6'h00, vin_hold_r, 6'h00, volt_r};
   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_user_no_lift;
      @(posedge pclk) disable iff (!presetn)
      (vf_user && lift_mode == dbs_pkg::LIFT_MANUAL) |-> lift_v == 20'h00000;
   endproperty
   a_user_no_lift: assert property (p_user_no_lift) else $error("lift with user pattern"); // R18
   property p_vin_limit;
      @(posedge pclk) disable iff (!presetn)
      (rated != 10'h000 && rated > vin_meas && drive_nxt) |=> volt_r <= $past(vin_meas);
   endproperty
   a_vin_limit: assert property (p_vin_limit) else $error("voltage above input"); // R7
   property p_base_volt;
      @(posedge pclk) disable iff (!presetn)
      (rated != 10'h000 && rated <= vin_meas && above_base && drive_nxt) |=>
         volt_r == $past(rated);
   endproperty
   a_base_volt: assert property (p_base_volt) else $error("wrong voltage above base"); // R6
   property p_direct_start;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_IDLE && run_cmd && start_mode == dbs_pkg::LAUNCH_DIRECT) |=>
         state_r == dbs_pkg::ST_RUN && output_on;
   endproperty
   a_direct_start: assert property (p_direct_start) else $error("direct start late"); // R9
   property p_launch_inj;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_IDLE && run_cmd && start_mode) |=>
         dc_inject && !output_on && dc_level == $past(launch_injection_amount);
   endproperty
   a_launch_inj: assert property (p_launch_inj) else $error("launch injection missing"); // R10
   property p_launch_lvl;
      @(posedge pclk) disable iff (!presetn)
      state_r == dbs_pkg::ST_LAUNCH_INJ |-> dc_level <= dbs_pkg::INJ_MAX;
   endproperty
   a_launch_lvl: assert property (p_launch_lvl) else $error("launch level too high"); // R11
   property p_ramp_end;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_DECEL && !run_cmd && freq_r == 16'h0000 && !stop_mode) |=>
         state_r == dbs_pkg::ST_IDLE && !output_on;
   endproperty
   a_ramp_end: assert property (p_ramp_end) else $error("ramp stop did not end"); // R12
   property p_thresh;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_DECEL && !run_cmd && stop_mode && at_thresh) |=>
         state_r == dbs_pkg::ST_BLOCK;
   endproperty
   a_thresh: assert property (p_thresh) else $error("no block at threshold"); // R13
   property p_block_off;
      @(posedge pclk) disable iff (!presetn)
      state_r == dbs_pkg::ST_BLOCK |-> !output_on && !dc_inject && volt_cmd == 10'h000;
   endproperty
   a_block_off: assert property (p_block_off) else $error("output live while blocked"); // R14
   property p_halt_end;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_HALT_INJ && expired) |=>
         state_r == dbs_pkg::ST_IDLE && !dc_inject && !output_on;
   endproperty
   a_halt_end: assert property (p_halt_end) else $error("halt injection did not end"); // R19
   property p_skip_dwell;
      @(posedge pclk) disable iff (!presetn)
      (state_r == dbs_pkg::ST_DECEL && dwell_freq < halt_injection_threshold) |=>
         state_r != dbs_pkg::ST_DWELL;
   endproperty
   a_skip_dwell: assert property (p_skip_dwell) else $error("dwell below threshold"); // R17
endmodule
`default_nettype wire

// ==== verilog/dbs_pkg.sv ====
// Purpose: Shared constants for the drive boost and start-stop sequencer
// Assumes: 32-bit APB data, 100 MHz pclk
// Notes: Register byte address is four times the register index
`default_nettype none
package dbs_pkg;
   // Clocking and sequencer tick
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TIME_W = 13;
   localparam logic [12:0] TIME_MAX = 13'h1770;
   // Register indices
   localparam int NREG_CFG = 9;
   localparam int NREG = 11;
   localparam int IDX_W = 4;
   localparam int ADDR_LSB = 2;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_LIFT = 4'h1;
   localparam logic [3:0] REG_MODEL = 4'h2;
   localparam logic [3:0] REG_VOLT = 4'h3;
   localparam logic [3:0] REG_FREQ = 4'h4;
   localparam logic [3:0] REG_START = 4'h5;
   localparam logic [3:0] REG_STOP_T = 4'h6;
   localparam logic [3:0] REG_STOP_L = 4'h7;
   localparam logic [3:0] REG_DWELL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'h9;
   localparam logic [3:0] REG_VOUT = 4'ha;
   // Field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_REV = 1;
   localparam int CTRL_VF_USER = 2;
   localparam int CTRL_BOOST = 4;
   localparam int CTRL_START = 8;
   localparam int CTRL_STOP = 9;
   localparam int LO = 0;
   localparam int MID = 8;
   localparam int HI = 16;
   localparam logic [31:0] CFG_RST [0:NREG_CFG-1] = '{
      32'h0000_0000, 32'h0000_1414, 32'h0000_0000, 32'h0064_0000, 32'h1770_0000,
      32'h0032_0000, 32'h0064_000a, 32'h01f4_0032, 32'h0000_0000};
   // Limits, in 0.1 %, percent and volts
   localparam logic [7:0] LIFT_MAX = 8'h96;
   localparam logic [7:0] INJ_MAX = 8'hc8;
   localparam logic [9:0] RATED_MIN = 10'haa;
   localparam logic [9:0] RATED_MAX = 10'h1e0;
   localparam logic [9:0] PCT_SCALE = 10'h3e8;
   // Volt/frequency ratio, fixed point
   localparam int RATIO_BITS = 10;
   localparam logic [10:0] RATIO_ONE = 11'h400;
   localparam int MODEL_SHIFT = 16;
   localparam int CUR_SHIFT = 8;
   // Modes
   localparam logic [1:0] LIFT_MANUAL = 2'h0;
   localparam logic [1:0] MODEL_BASED_LIFT = 2'h1;
   localparam logic [1:0] CURRENT_BASED_LIFT = 2'h2;
   localparam logic LAUNCH_DIRECT = 1'b0;
   localparam logic INJECTION_THEN_LAUNCH = 1'b1;
   localparam logic HALT_RAMP = 1'b0;
   localparam logic HALT_INJECT = 1'b1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_LAUNCH_INJ, ST_RUN, ST_DECEL, ST_DWELL, ST_BLOCK, ST_HALT_INJ
   } dbs_state_e;
endpackage
`default_nettype wire

// ==== verilog/dbs_seq_timer.sv ====
// Purpose: 10 ms tick and loadable down counter for timed sequencer states
// Assumes: Load and decrement never needed in the same cycle by the caller
// Notes: Expired is combinational from the count
`timescale 1ns/1ps
`default_nettype none
module dbs_seq_timer #(
   parameter int TICK_CYCLES = dbs_pkg::TICK_CYCLES,
   parameter int TW = dbs_pkg::TIME_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [TW-1:0] load_val,
   output logic tick,
   output logic expired
);
   localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
   initial begin
      if (TICK_CYCLES < 1 || TW < 1) $error("dbs_seq_timer: bad parameters");
   end
   logic [PW-1:0] pre_r;
   logic [TW-1:0] cnt_r;
   logic tick_w;
   assign tick_w = (pre_r == PRE_LAST);
   assign tick = tick_w;
   assign expired = (cnt_r == '0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= '0;
         cnt_r <= '0;
      end else begin
         pre_r <= tick_w ? '0 : pre_r + 1'b1;
         if (load) begin
            cnt_r <= load_val; // R20
         end else if (tick_w && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1; // R20
         end
      end
   end
endmodule
`default_nettype wire
